// File: snp_pkg.sv
package snp_pkg;
	// Clock period of both ends, in nanoseconds.
	localparam int CLK_NS = 8;
	// Least waits after each kind of write, in milliseconds.
	localparam real FLASH_PAGE_WAIT_MS = 4.5;
	localparam real EEPROM_WRITE_WAIT_MS = 4.0;
	localparam real CHIP_ERASE_WAIT_MS = 4.0;
	localparam real FUSE_WRITE_WAIT_MS = 4.5;
	// Least waits rounded up to whole clock cycles.
	localparam int FLASH_WAIT_CYC = int'($ceil(FLASH_PAGE_WAIT_MS * 1.0e6 / CLK_NS));
	localparam int EEPROM_WAIT_CYC = int'($ceil(EEPROM_WRITE_WAIT_MS * 1.0e6 / CLK_NS));
	localparam int ERASE_WAIT_CYC = int'($ceil(CHIP_ERASE_WAIT_MS * 1.0e6 / CLK_NS));
	localparam int FUSE_WAIT_CYC = int'($ceil(FUSE_WRITE_WAIT_MS * 1.0e6 / CLK_NS));
	// Host link timing in clock cycles.
	localparam int SCK_HALF_CYC = 8;
	localparam int RESET_PULSE_CYC = 16;
	localparam int SETTLE_CYC = 16;
	// Instruction first bytes.
	localparam logic [7:0] OP_PROG_ENABLE = 8'hac;
	localparam logic [7:0] OP_LOAD_FL_LO = 8'h40;
	localparam logic [7:0] OP_LOAD_FL_HI = 8'h48;
	localparam logic [7:0] OP_WRITE_FL_PAGE = 8'h4c;
	localparam logic [7:0] OP_READ_FL_LO = 8'h20;
	localparam logic [7:0] OP_READ_FL_HI = 8'h28;
	localparam logic [7:0] OP_EE_WRITE = 8'hc0;
	localparam logic [7:0] OP_EE_LOAD = 8'hc1;
	localparam logic [7:0] OP_EE_PAGE = 8'hc2;
	localparam logic [7:0] OP_EE_READ = 8'ha0;
	localparam logic [7:0] OP_FUSE_READ = 8'h50;
	localparam logic [7:0] OP_POLL = 8'hf0;
	// Second bytes under the enable opcode, and fuse read selectors.
	localparam logic [7:0] ENABLE_ECHO = 8'h53;
	localparam logic [7:0] SUB_CHIP_ERASE = 8'h80;
	localparam logic [7:0] SUB_FUSE_LO = 8'ha0;
	localparam logic [7:0] SUB_FUSE_HI = 8'ha8;
	localparam logic [7:0] SUB_FUSE_EXT = 8'ha4;
	localparam logic [7:0] FSEL_LO = 8'h00;
	localparam logic [7:0] FSEL_HI = 8'h08;
	localparam logic [7:0] FSEL_EXT = 8'h04;
	// Fuse bit positions; a programmed fuse is 0.
	localparam int FH_EXT_RESET_DIS = 7;
	localparam int FH_DEBUG_LINK_EN = 6;
	localparam int FH_SERIAL_PROG_EN = 5;
	localparam int FH_WATCHDOG_ON = 4;
	localparam int FH_EE_KEEP = 3;
	localparam int FE_SELF_WRITE = 0;
	// Fuse values after reset, and the unused extended fuse bits forced to 1.
	localparam logic [7:0] FUSE_LO_RST = 8'hff;
	localparam logic [7:0] FUSE_HI_RST = 8'hdf;
	localparam logic [7:0] FUSE_EXT_RST = 8'hff;
	localparam logic [7:0] FUSE_EXT_UNUSED = 8'hfe;
	// Page geometry: in-page address bits and page-select bits.
	localparam int FL_PAGE_AW = 5;
	localparam int FL_PAGE_SEL_W = 6;
	localparam int EE_PAGE_AW = 2;
	localparam int EE_PAGE_SEL_W = 6;
	// Host sequencer states.
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_SEND = 2'b01,
		H_PULSE = 2'b10,
		H_WAIT = 2'b11
	} snp_host_state_e;
endpackage

// File: snp_link_if.sv
interface snp_link_if;
	// Serial clock, driven by the programmer, idles low.
	logic sck;
	// Programmer to device data.
	logic mosi;
	// Device to programmer data.
	logic miso;
	// Device reset pin; low holds the device for programming.
	logic targetResetN;
	modport device (
		input sck,
		input mosi,
		input targetResetN,
		output miso
	);
	modport host (
		output sck,
		output mosi,
		output targetResetN,
		input miso
	);
endinterface

// File: snp_shift.sv
module snp_shift (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Bit timing.
	input wire logic start,
	input wire logic sampleEn,
	input wire logic shiftEn,
	// Data.
	input wire logic inBit,
	input wire logic [7:0] loadByte,
	output logic txBit,
	output logic byteDone,
	output logic [7:0] rxNext
);
	logic [7:0] tx_r, tx_nxt, rx_r, rx_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic skip_r, skip_nxt;
	logic hold_r, hold_nxt;

	// Bits are taken on sampleEn and moved out on shiftEn, MSB first.
	assign rxNext = {rx_r[6:0], inBit};
	assign byteDone = sampleEn && (cnt_r == 3'h7);
	assign txBit = skip_r ? hold_r : tx_r[7];

	// The next byte is loaded when a byte completes, but the last bit of the
	// old byte is held on the line until the following shift edge. Showing
	// the new bit at once would move the data while the clock is high.
	always_comb begin
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		cnt_nxt = cnt_r;
		skip_nxt = skip_r;
		hold_nxt = hold_r;
		if (start) begin
			tx_nxt = loadByte;
			rx_nxt = 8'h00;
			cnt_nxt = 3'h0;
			skip_nxt = 1'b0;
		end else if (sampleEn) begin
			rx_nxt = rxNext;
			cnt_nxt = cnt_r + 3'h1;
			if (byteDone) begin
				tx_nxt = loadByte;
				hold_nxt = tx_r[7];
				skip_nxt = 1'b1;
			end
		end else if (shiftEn) begin
			if (skip_r) begin
				skip_nxt = 1'b0;
			end else begin
				tx_nxt = {tx_r[6:0], 1'b0};
			end
		end
	end

	// Registers.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_r <= 8'h00;
			rx_r <= 8'h00;
			cnt_r <= 3'h0;
			skip_r <= 1'b0;
			hold_r <= 1'b0;
		end else begin
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			cnt_r <= cnt_nxt;
			skip_r <= skip_nxt;
			hold_r <= hold_nxt;
		end
	end
endmodule

// File: snp_device.sv
module snp_device #(
	parameter int FLASH_WAIT = snp_pkg::FLASH_WAIT_CYC,
	parameter int EEPROM_WAIT = snp_pkg::EEPROM_WAIT_CYC,
	parameter int ERASE_WAIT = snp_pkg::ERASE_WAIT_CYC,
	parameter int FUSE_WAIT = snp_pkg::FUSE_WAIT_CYC,
	parameter logic [7:0] FUSE_LO_DEFAULT = snp_pkg::FUSE_LO_RST
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Programming link.
	snp_link_if.device link,
	// Device state.
	output logic progMode,
	output logic normalRun,
	output logic writeBusy,
	// Fuse bytes and their effects.
	output logic [7:0] fuseLow,
	output logic [7:0] fuseHigh,
	output logic [7:0] fuseExt,
	output logic selfWriteAllow
);
	import snp_pkg::*;

	localparam int FL_AW = FL_PAGE_AW + FL_PAGE_SEL_W;
	localparam int FL_WORDS = 1 << FL_AW;
	localparam int FL_PAGE = 1 << FL_PAGE_AW;
	localparam int EE_AW = EE_PAGE_AW + EE_PAGE_SEL_W;
	localparam int EE_BYTES = 1 << EE_AW;
	localparam int EE_PAGE = 1 << EE_PAGE_AW;

	logic [1:0] sckSync_r, sckSync_nxt, mosiSync_r, mosiSync_nxt;
	logic [1:0] rstnSync_r, rstnSync_nxt;
	logic sckPrev_r, sckPrev_nxt;
	logic [15:0] flash_r [FL_WORDS];
	logic [15:0] flash_nxt [FL_WORDS];
	logic [15:0] fbuf_r [FL_PAGE];
	logic [15:0] fbuf_nxt [FL_PAGE];
	logic [7:0] ee_r [EE_BYTES];
	logic [7:0] ee_nxt [EE_BYTES];
	logic [7:0] ebuf_r [EE_PAGE];
	logic [7:0] ebuf_nxt [EE_PAGE];
	logic [EE_PAGE-1:0] eeMask_r, eeMask_nxt;
	logic [7:0] bytes_r [3];
	logic [7:0] bytes_nxt [3];
	logic [1:0] idx_r, idx_nxt;
	logic enabled_r, enabled_nxt;
	logic [31:0] busyCnt_r, busyCnt_nxt;
	logic [7:0] fLo_r, fLo_nxt, fHi_r, fHi_nxt, fExt_r, fExt_nxt;
	logic rise, fall, rstnHigh, busy, byteDone;
	logic [7:0] rxNext, txNext, rdByte, op, sel, lowAddr;
	logic [15:0] addr16;
	logic [FL_AW-1:0] wAddr;
	logic [EE_AW-1:0] eAddr;

	// Edges of the synchronised link clock; data moves out on the fall.
	assign rise = sckSync_r[1] && !sckPrev_r;
	assign fall = !sckSync_r[1] && sckPrev_r;
	assign rstnHigh = rstnSync_r[1];
	assign busy = busyCnt_r != 32'h0;

	// Fields of the instruction; the third byte is live at its own end.
	assign op = bytes_r[0];
	assign sel = bytes_r[1];
	assign lowAddr = (idx_r == 2'd3) ? bytes_r[2] : rxNext;
	assign addr16 = {sel, lowAddr};
	assign wAddr = addr16[FL_AW-1:0];
	assign eAddr = addr16[EE_AW-1:0];

	// Outputs; a stored 0 is a programmed fuse, seen alike inside.
	assign progMode = enabled_r;
	assign normalRun = rstnHigh;
	assign writeBusy = busy;
	assign fuseLow = fLo_r;
	assign fuseHigh = fHi_r;
	assign fuseExt = fExt_r;
	assign selfWriteAllow = !fExt_r[FE_SELF_WRITE];

	snp_shift u_shift (
		.clk(clk),
		.rst(rst),
		.start(rstnHigh),
		.sampleEn(rise),
		.shiftEn(fall),
		.inBit(mosiSync_r[1]),
		.loadByte(txNext),
		.txBit(link.miso),
		.byteDone(byteDone),
		.rxNext(rxNext)
	);

	// Byte presented in the fourth slot of a read instruction.
	always_comb begin
		rdByte = 8'h00;
		if (enabled_r) begin
			case (op)
				OP_READ_FL_LO: rdByte = flash_r[wAddr][7:0];
				OP_READ_FL_HI: rdByte = flash_r[wAddr][15:8];
				OP_EE_READ: rdByte = ee_r[eAddr];
				OP_POLL: rdByte = {7'h00, busy};
				OP_FUSE_READ: begin
					if (sel == FSEL_LO) begin
						rdByte = fLo_r;
					end else if (sel == FSEL_HI) begin
						rdByte = fHi_r;
					end else if (sel == FSEL_EXT) begin
						rdByte = fExt_r;
					end
				end
				default: rdByte = 8'h00;
			endcase
		end
	end

	// Next byte to send: the previous byte is echoed, the read answer goes
	// out last. Even a device not yet enabled echoes, so sync can be found.
	always_comb begin
		if (rstnHigh || idx_r == 2'd3) begin
			txNext = 8'h00;
		end else if (idx_r == 2'd2) begin
			txNext = rdByte;
		end else begin
			txNext = rxNext;
		end
	end

	// Instruction decode and all memory updates. Writes arriving while the
	// previous one still counts down are dropped rather than corrupting it.
	always_comb begin
		sckSync_nxt = {sckSync_r[0], link.sck};
		mosiSync_nxt = {mosiSync_r[0], link.mosi};
		rstnSync_nxt = {rstnSync_r[0], link.targetResetN};
		sckPrev_nxt = sckSync_r[1];
		flash_nxt = flash_r;
		fbuf_nxt = fbuf_r;
		ee_nxt = ee_r;
		ebuf_nxt = ebuf_r;
		eeMask_nxt = eeMask_r;
		bytes_nxt = bytes_r;
		idx_nxt = idx_r;
		enabled_nxt = enabled_r;
		busyCnt_nxt = busy ? busyCnt_r - 32'h1 : 32'h0;
		fLo_nxt = fLo_r;
		fHi_nxt = fHi_r;
		fExt_nxt = fExt_r;
		if (rstnHigh) begin
			idx_nxt = 2'd0;
			enabled_nxt = 1'b0;
		end else if (byteDone) begin
			if (idx_r != 2'd3) begin
				bytes_nxt[idx_r] = rxNext;
				idx_nxt = idx_r + 2'd1;
			end else begin
				idx_nxt = 2'd0;
				if (!enabled_r) begin
					if (op == OP_PROG_ENABLE && sel == ENABLE_ECHO) begin
						enabled_nxt = 1'b1;
					end
				end else begin
					case (op)
						OP_LOAD_FL_LO: begin
							fbuf_nxt[lowAddr[FL_PAGE_AW-1:0]][7:0] = rxNext;
						end
						OP_LOAD_FL_HI: begin
							fbuf_nxt[lowAddr[FL_PAGE_AW-1:0]][15:8] = rxNext;
						end
						OP_WRITE_FL_PAGE: begin
							if (!busy) begin
								for (int i = 0; i < FL_PAGE; i++) begin
									flash_nxt[{wAddr[FL_AW-1:FL_PAGE_AW],
										FL_PAGE_AW'(i)}] = fbuf_r[i];
								end
								busyCnt_nxt = 32'(FLASH_WAIT);
							end
						end
						OP_EE_WRITE: begin
							if (!busy) begin
								ee_nxt[eAddr] = rxNext;
								busyCnt_nxt = 32'(EEPROM_WAIT);
							end
						end
						OP_EE_LOAD: begin
							ebuf_nxt[lowAddr[EE_PAGE_AW-1:0]] = rxNext;
							eeMask_nxt[lowAddr[EE_PAGE_AW-1:0]] = 1'b1;
						end
						OP_EE_PAGE: begin
							if (!busy) begin
								for (int i = 0; i < EE_PAGE; i++) begin
									if (eeMask_r[i]) begin
										ee_nxt[{eAddr[EE_AW-1:EE_PAGE_AW],
											EE_PAGE_AW'(i)}] = ebuf_r[i];
									end
								end
								eeMask_nxt = '0;
								busyCnt_nxt = 32'(EEPROM_WAIT);
							end
						end
						OP_PROG_ENABLE: begin
							if (!busy) begin
								if (sel == SUB_CHIP_ERASE) begin
									for (int i = 0; i < FL_WORDS; i++) begin
										flash_nxt[i] = 16'hffff;
									end
									if (fHi_r[FH_EE_KEEP]) begin
										for (int i = 0; i < EE_BYTES; i++) begin
											ee_nxt[i] = 8'hff;
										end
									end
									busyCnt_nxt = 32'(ERASE_WAIT);
								end else if (sel == SUB_FUSE_LO) begin
									fLo_nxt = rxNext;
									busyCnt_nxt = 32'(FUSE_WAIT);
								end else if (sel == SUB_FUSE_HI) begin
									fHi_nxt = rxNext;
									fHi_nxt[FH_SERIAL_PROG_EN] = fHi_r[FH_SERIAL_PROG_EN];
									busyCnt_nxt = 32'(FUSE_WAIT);
								end else if (sel == SUB_FUSE_EXT) begin
									fExt_nxt = rxNext | FUSE_EXT_UNUSED;
									busyCnt_nxt = 32'(FUSE_WAIT);
								end
							end
						end
						default: enabled_nxt = enabled_r;
					endcase
				end
			end
		end
	end

	// Registers; memories come up erased and fuses at their defaults.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sckSync_r <= 2'h0;
			mosiSync_r <= 2'h0;
			rstnSync_r <= 2'h3;
			sckPrev_r <= 1'b0;
			for (int i = 0; i < FL_WORDS; i++) begin
				flash_r[i] <= 16'hffff;
			end
			for (int i = 0; i < FL_PAGE; i++) begin
				fbuf_r[i] <= 16'hffff;
			end
			for (int i = 0; i < EE_BYTES; i++) begin
				ee_r[i] <= 8'hff;
			end
			for (int i = 0; i < EE_PAGE; i++) begin
				ebuf_r[i] <= 8'hff;
			end
			for (int i = 0; i < 3; i++) begin
				bytes_r[i] <= 8'h00;
			end
			eeMask_r <= '0;
			idx_r <= 2'd0;
			enabled_r <= 1'b0;
			busyCnt_r <= 32'h0;
			fLo_r <= FUSE_LO_DEFAULT;
			fHi_r <= FUSE_HI_RST;
			fExt_r <= FUSE_EXT_RST;
		end else begin
			sckSync_r <= sckSync_nxt;
			mosiSync_r <= mosiSync_nxt;
			rstnSync_r <= rstnSync_nxt;
			sckPrev_r <= sckPrev_nxt;
			flash_r <= flash_nxt;
			fbuf_r <= fbuf_nxt;
			ee_r <= ee_nxt;
			ebuf_r <= ebuf_nxt;
			bytes_r <= bytes_nxt;
			eeMask_r <= eeMask_nxt;
			idx_r <= idx_nxt;
			enabled_r <= enabled_nxt;
			busyCnt_r <= busyCnt_nxt;
			fLo_r <= fLo_nxt;
			fHi_r <= fHi_nxt;
			fExt_r <= fExt_nxt;
		end
	end
endmodule

// File: snp_host.sv
module snp_host #(
	parameter int SCK_HALF = snp_pkg::SCK_HALF_CYC,
	parameter int FLASH_WAIT = snp_pkg::FLASH_WAIT_CYC,
	parameter int EEPROM_WAIT = snp_pkg::EEPROM_WAIT_CYC,
	parameter int ERASE_WAIT = snp_pkg::ERASE_WAIT_CYC,
	parameter int FUSE_WAIT = snp_pkg::FUSE_WAIT_CYC
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Programming link.
	snp_link_if.host link,
	// Session control.
	input wire logic sessionOn,
	// Instruction request.
	input wire logic cmdValid,
	input wire logic [31:0] cmdWord,
	output logic cmdReady,
	// Answer.
	output logic rspValid,
	output logic [7:0] rspByte,
	output logic echoFail
);
	import snp_pkg::*;

	snp_host_state_e state_r, state_nxt;
	logic [15:0] half_r, half_nxt;
	logic sck_r, sck_nxt, last_r, last_nxt, pend_r, pend_nxt;
	logic resetN_r, resetN_nxt, rspValid_r, rspValid_nxt;
	logic echoFail_r, echoFail_nxt;
	logic [1:0] byteIdx_r, byteIdx_nxt, misoSync_r, misoSync_nxt;
	logic [31:0] cmd_r, cmd_nxt, rx_r, rx_nxt, wait_r, wait_nxt;
	logic [7:0] settle_r, settle_nxt, rspByte_r, rspByte_nxt;
	logic [7:0] loadByte, rxNext;
	logic toggle, rise, fall, start, settled, byteDone;
	logic [31:0] waitLoad;

	assign settled = settle_r == 8'(SETTLE_CYC);
	assign cmdReady = state_r == H_IDLE && settled && !pend_r && sessionOn;
	assign start = state_r == H_IDLE && settled && (pend_r || (cmdReady && cmdValid));
	assign toggle = state_r == H_SEND && half_r == 16'(SCK_HALF - 1);
	assign rise = toggle && !sck_r;
	assign fall = toggle && sck_r;
	assign link.sck = sck_r;
	assign link.targetResetN = resetN_r;
	assign rspValid = rspValid_r;
	assign rspByte = rspByte_r;
	assign echoFail = echoFail_r;

	// First byte on start; otherwise the byte after the one just done.
	always_comb begin
		if (start) begin
			loadByte = pend_r ? cmd_r[31:24] : cmdWord[31:24];
		end else begin
			case (byteIdx_r)
				2'd0: loadByte = cmd_r[23:16];
				2'd1: loadByte = cmd_r[15:8];
				2'd2: loadByte = cmd_r[7:0];
				default: loadByte = 8'h00;
			endcase
		end
	end

	// Wait owed after a write; polling is not used by this sequencer.
	always_comb begin
		waitLoad = 32'h0;
		if (cmd_r[31:24] == OP_WRITE_FL_PAGE) begin
			waitLoad = 32'(FLASH_WAIT);
		end else if (cmd_r[31:24] == OP_EE_WRITE) begin
			waitLoad = 32'(EEPROM_WAIT);
		end else if (cmd_r[31:24] == OP_EE_PAGE) begin
			waitLoad = 32'(EEPROM_WAIT);
		end else if (cmd_r[31:24] == OP_PROG_ENABLE) begin
			if (cmd_r[23:16] == SUB_CHIP_ERASE) begin
				waitLoad = 32'(ERASE_WAIT);
			end else if (cmd_r[23:16] != ENABLE_ECHO) begin
				waitLoad = 32'(FUSE_WAIT);
			end
		end
	end

	snp_shift u_shift (
		.clk(clk),
		.rst(rst),
		.start(start),
		.sampleEn(rise),
		.shiftEn(fall),
		.inBit(misoSync_r[1]),
		.loadByte(loadByte),
		.txBit(link.mosi),
		.byteDone(byteDone),
		.rxNext(rxNext)
	);

	// Sequencer: every instruction goes out whole, then the echo of the enable instruction is judged.
	always_comb begin
		state_nxt = state_r;
		half_nxt = toggle ? 16'h0 : (state_r == H_SEND ? half_r + 16'h1 : 16'h0);
		sck_nxt = toggle ? !sck_r : sck_r;
		last_nxt = last_r;
		pend_nxt = pend_r;
		byteIdx_nxt = byteIdx_r;
		misoSync_nxt = {misoSync_r[0], link.miso};
		cmd_nxt = cmd_r;
		rx_nxt = rx_r;
		wait_nxt = wait_r;
		rspValid_nxt = 1'b0;
		rspByte_nxt = rspByte_r;
		echoFail_nxt = 1'b0;
		resetN_nxt = !sessionOn || state_r == H_PULSE;
		settle_nxt = resetN_r ? 8'h0 : (settled ? settle_r : settle_r + 8'h1);
		case (state_r)
			H_IDLE: begin
				if (start) begin
					if (!pend_r) begin
						cmd_nxt = cmdWord;
					end
					pend_nxt = 1'b0;
					byteIdx_nxt = 2'd0;
					last_nxt = 1'b0;
					state_nxt = H_SEND;
				end
			end
			H_SEND: begin
				if (byteDone) begin
					rx_nxt = {rx_r[23:0], rxNext};
					byteIdx_nxt = byteIdx_r + 2'd1;
					last_nxt = byteIdx_r == 2'd3;
				end
				if (fall && last_r) begin
					if (cmd_r[31:16] == {OP_PROG_ENABLE, ENABLE_ECHO} &&
						rx_r[15:8] != ENABLE_ECHO) begin
						echoFail_nxt = 1'b1;
						pend_nxt = 1'b1;
						wait_nxt = 32'(RESET_PULSE_CYC);
						state_nxt = H_PULSE;
					end else begin
						rspValid_nxt = 1'b1;
						rspByte_nxt = rx_r[7:0];
						wait_nxt = waitLoad;
						state_nxt = H_WAIT;
					end
				end
			end
			H_PULSE: begin
				wait_nxt = wait_r - 32'h1;
				if (wait_r == 32'h0) begin
					state_nxt = H_IDLE;
				end
			end
			H_WAIT: begin
				wait_nxt = wait_r == 32'h0 ? 32'h0 : wait_r - 32'h1;
				if (wait_r == 32'h0) begin
					state_nxt = H_IDLE;
				end
			end
			default: state_nxt = H_IDLE;
		endcase
	end

	// Registers; the target is left running until a session is asked for.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= H_IDLE;
			half_r <= 16'h0;
			sck_r <= 1'b0;
			last_r <= 1'b0;
			pend_r <= 1'b0;
			byteIdx_r <= 2'd0;
			misoSync_r <= 2'h0;
			cmd_r <= 32'h0;
			rx_r <= 32'h0;
			wait_r <= 32'h0;
			rspValid_r <= 1'b0;
			rspByte_r <= 8'h00;
			echoFail_r <= 1'b0;
			resetN_r <= 1'b1;
			settle_r <= 8'h0;
		end else begin
			state_r <= state_nxt;
			half_r <= half_nxt;
			sck_r <= sck_nxt;
			last_r <= last_nxt;
			pend_r <= pend_nxt;
			byteIdx_r <= byteIdx_nxt;
			misoSync_r <= misoSync_nxt;
			cmd_r <= cmd_nxt;
			rx_r <= rx_nxt;
			wait_r <= wait_nxt;
			rspValid_r <= rspValid_nxt;
			rspByte_r <= rspByte_nxt;
			echoFail_r <= echoFail_nxt;
			resetN_r <= resetN_nxt;
			settle_r <= settle_nxt;
		end
	end
endmodule

// File: snp_props.sv
module snp_props (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Link wires.
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic targetResetN
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic sckQ_r, sckQ_nxt;
	logic [4:0] bitCnt_r, bitCnt_nxt;

	// Count clock rises modulo one instruction of 32 bits.
	always_comb begin
		sckQ_nxt = sck;
		bitCnt_nxt = bitCnt_r + {4'h0, sck & ~sckQ_r};
	end

	// Registers of the bit counter.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sckQ_r <= 1'b0;
			bitCnt_r <= 5'h00;
		end else begin
			sckQ_r <= sckQ_nxt;
			bitCnt_r <= bitCnt_nxt;
		end
	end

	a_mosi_low_only: assert property ($changed(mosi) |-> !sck)
		else $error("mosi moved while sck high");
	a_sck_high_width: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
		else $error("sck high phase wrong");
	a_sck_low_width: assert property ($fell(sck) |-> !sck[*8])
		else $error("sck low phase too short");
	a_miso_steady_high: assert property (sck && $past(sck) |-> $stable(miso))
		else $error("miso moved while sck high");
	a_sck_idle_out: assert property (targetResetN |-> !sck)
		else $error("sck toggled outside session");
	a_reset_pulse_len: assert property ($rose(targetResetN) |-> targetResetN[*8])
		else $error("reset pulse too short");
	a_settle_first: assert property ($fell(targetResetN) |-> !sck[*8])
		else $error("sck rose too soon after reset low");
	// A session or retry may only break between whole instructions.
	a_whole_frames: assert property ($rose(targetResetN) |-> bitCnt_r == 5'h00)
		else $error("reset pin rose mid instruction");

	c_session: cover property ($fell(targetResetN));
	c_pulse: cover property ($rose(targetResetN));
	c_frame: cover property (bitCnt_r == 5'h1f && $fell(sck));
endmodule

// File: test_serial_nvm_programming.sv
module test_serial_nvm_programming;
	timeunit 1ns;
	timeprecision 1ps;
	import snp_pkg::*;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sessionOn = 1'b0;
	logic cmdValid = 1'b0;
	logic [31:0] cmdWord = 32'h0;
	logic cmdReady, rspValid, echoFail, echoSeen;
	logic progMode, normalRun, writeBusy, selfWriteAllow;
	logic [7:0] rspByte, fuseLow, fuseHigh, fuseExt;
	int err_total = 0;
	int samples_checked = 0;

	// Both ends meet on one link; waits shortened to keep the run short.
	localparam int WAIT_CYC = 50;
	snp_link_if snp_link_if_i ();
	snp_host #(.FLASH_WAIT(WAIT_CYC), .EEPROM_WAIT(WAIT_CYC),
		.ERASE_WAIT(WAIT_CYC), .FUSE_WAIT(WAIT_CYC))
		snp_host_i (.clk(clk), .rst(rst),
		.link(snp_link_if_i), .sessionOn(sessionOn), .cmdValid(cmdValid),
		.cmdWord(cmdWord), .cmdReady(cmdReady), .rspValid(rspValid),
		.rspByte(rspByte), .echoFail(echoFail));
	snp_device #(.FLASH_WAIT(WAIT_CYC), .EEPROM_WAIT(WAIT_CYC),
		.ERASE_WAIT(WAIT_CYC), .FUSE_WAIT(WAIT_CYC))
		snp_device_i (.clk(clk), .rst(rst),
		.link(snp_link_if_i), .progMode(progMode), .normalRun(normalRun),
		.writeBusy(writeBusy), .fuseLow(fuseLow), .fuseHigh(fuseHigh),
		.fuseExt(fuseExt), .selfWriteAllow(selfWriteAllow));
	snp_props snp_props_i (.clk(clk), .rst(rst), .sck(snp_link_if_i.sck),
		.mosi(snp_link_if_i.mosi), .miso(snp_link_if_i.miso),
		.targetResetN(snp_link_if_i.targetResetN));

	// Free-running clock.
	always #4 clk = ~clk;

	task automatic finish_test();
		if (err_total == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask

	// One instruction; waits are bounded so a stuck end cannot hang us.
	task automatic xfer(input logic [31:0] w, output logic [7:0] r);
		int n;
		n = 0;
		echoSeen = 1'b0;
		do begin
			@(negedge clk);
			n++;
		end while (cmdReady !== 1'b1 && n < 3000);
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdWord <= w;
		@(posedge clk);
		cmdValid <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
			if (echoFail === 1'b1) echoSeen = 1'b1;
		end while (rspValid !== 1'b1 && n < 3000);
		if (n >= 3000) chk("answer", 8'h01, 8'h00);
		r = rspByte;
	endtask

	task automatic wr(input logic [31:0] w);
		logic [7:0] r;
		xfer(w, r);
	endtask

	task automatic rd(input logic [31:0] w, input logic [7:0] e);
		logic [7:0] r;
		xfer(w, r);
		chk($sformatf("read %h", w), e, r);
	endtask

	task automatic t_reset();
		chk("fuseLow", 8'hff, fuseLow);
		chk("fuseHigh", 8'hdf, fuseHigh);
		chk("fuseExt", 8'hff, fuseExt);
		chk("selfWrite", 8'h00, {7'h0, selfWriteAllow});
		chk("progMode", 8'h00, {7'h0, progMode});
	endtask

	task automatic t_locked();
		@(posedge clk);
		sessionOn <= 1'b1;
		wr(32'hc000_05aa);
		chk("normalRun", 8'h00, {7'h0, normalRun});
		wr(32'hac53_0000);
		chk("echoFail", 8'h00, {7'h0, echoSeen});
		chk("progMode", 8'h01, {7'h0, progMode});
		rd(32'ha000_0500, 8'hff);
	endtask

	task automatic t_ee();
		logic [7:0] exp [4] = '{8'h11, 8'h3c, 8'h22, 8'hff};
		wr(32'hc000_053c);
		chk("writeBusy", 8'h01, {7'h0, writeBusy});
		rd(32'hf000_0000, 8'h00);
		rd(32'ha000_0500, 8'h3c);
		wr(32'hc100_0011);
		wr(32'hc100_0222);
		wr(32'hc200_0400);
		for (int i = 0; i < 4; i++) begin
			rd({16'ha000, 8'(4 + i), 8'h00}, exp[i]);
		end
	endtask

	task automatic t_flash();
		wr(32'h4000_0334);
		wr(32'h4800_0312);
		wr(32'h4c00_4000);
		rd(32'h2000_4300, 8'h34);
		rd(32'h2800_4300, 8'h12);
	endtask

	task automatic t_fuse();
		wr(32'haca8_00ff);
		rd(32'h5008_0000, 8'hdf);
		wr(32'haca4_0000);
		rd(32'h5004_0000, 8'hfe);
		chk("selfWrite", 8'h01, {7'h0, selfWriteAllow});
		wr(32'haca0_00e2);
		rd(32'h5000_0000, 8'he2);
		chk("fuseLow", 8'he2, fuseLow);
	endtask

	// Erase with and without the keep fuse; flash is checked clear after the first erase only.
	task automatic t_erase();
		wr(32'haca8_00f7);
		chk("fuseHigh", 8'hd7, fuseHigh);
		wr(32'hac80_0000);
		rd(32'ha000_0500, 8'h3c);
		rd(32'h2000_4300, 8'hff);
		wr(32'haca8_00ff);
		wr(32'hac80_0000);
		rd(32'ha000_0500, 8'hff);
	endtask

	task automatic t_end();
		int n;
		n = 0;
		@(posedge clk);
		sessionOn <= 1'b0;
		do begin
			@(negedge clk);
			n++;
		end while (progMode !== 1'b0 && n < 200);
		chk("progMode", 8'h00, {7'h0, progMode});
		chk("normalRun", 8'h01, {7'h0, normalRun});
	endtask

	// Main sequence.
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		t_reset();
		t_locked();
		t_ee();
		t_flash();
		t_fuse();
		t_erase();
		t_end();
		finish_test();
	end

	// Some 31 instructions of about 530 cycles take about a third of this span, so
	// only a hung end reaches it.
	initial begin
		#400000;
		err_total++;
		finish_test();
	end
endmodule
